/* pkg/lvd_pkg.sv */
// lvd_pkg: register map, field positions, reset values and timing of the low-voltage monitor
package lvd_pkg;

  // register offsets on the 9-bit register address
  localparam logic [8:0] ADDR_CORE_IRQ_CTRL = 9'h00b;
  localparam logic [8:0] ADDR_PERIPH_FLAGS_TWO = 9'h00d;
  localparam logic [8:0] ADDR_PERIPH_ENABLES_TWO = 9'h08d;
  localparam logic [8:0] ADDR_LOW_VOLTAGE_CTRL = 9'h109;

  // core_interrupt_control fields
  localparam int unsigned GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int unsigned PERIPH_IRQ_ENABLE_BIT = 6;
  // low_voltage_flag / low_voltage_irq_enable share this position
  localparam int unsigned LOW_VOLTAGE_BIT = 2;

  // low_voltage_control fields
  localparam int unsigned REF_STABLE_BIT = 5;
  localparam int unsigned POWER_ENABLE_BIT = 4;
  localparam int unsigned TRIP_LSB = 0;
  localparam int unsigned TRIP_WIDTH = 3;

  // reset values
  localparam logic [7:0] CORE_IRQ_CTRL_RESET = 8'h00;
  localparam logic [7:0] PERIPH_FLAGS_TWO_RESET = 8'h00;
  localparam logic [7:0] PERIPH_ENABLES_TWO_RESET = 8'h00;
  localparam logic [7:0] LOW_VOLTAGE_CTRL_RESET = 8'h04;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // eight nominal trip levels
  typedef enum logic [2:0] {
    LVD_TRIP_1V9 = 3'h0,
    LVD_TRIP_2V0 = 3'h1,
    LVD_TRIP_2V1 = 3'h2,
    LVD_TRIP_2V2 = 3'h3,
    LVD_TRIP_2V3 = 3'h4,
    LVD_TRIP_4V0 = 3'h5,
    LVD_TRIP_4V2 = 3'h6,
    LVD_TRIP_4V5 = 3'h7
  } lvd_trip_type;
  localparam lvd_trip_type TRIP_RESET = LVD_TRIP_2V3;

  // monitor power state, one-hot
  typedef enum logic [2:0] {
    LVD_OFF = 3'h1,
    LVD_SETTLE = 3'h2,
    LVD_READY = 3'h4
  } lvd_state_type;

  // settling wait after power-up, worst case supply
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SETTLE_US = 50;
  localparam int unsigned SETTLE_CYCLES = SETTLE_US * CLK_MHZ;

  // synchronised pin inputs: supply_low, ref_ready, fast_osc_on, trim byte
  localparam int unsigned SYNC_WIDTH = 11;
  localparam int unsigned TRIM_WIDTH = 8;

endpackage : lvd_pkg

/* pkg/lvd_sync_if.sv */
// lvd_sync_if: raw pin levels in, synchronised levels out
`timescale 1ns/10ps
`default_nettype none
interface lvd_sync_if #(
  parameter int unsigned W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface : lvd_sync_if
`default_nettype wire

/* rtl/lvd_sync.sv */
// lvd_sync: two-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module lvd_sync #(
  parameter int unsigned W = 1
)(
  input wire logic i_clk,
  input wire logic i_rstn,
  lvd_sync_if.dst port
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= port.raw;
      stage2 <= stage1;
    end
  end

  assign port.sync = stage2;
endmodule : lvd_sync
`default_nettype wire

/* rtl/lvd_top.sv */
// lvd_top: control, status and interrupt logic of the programmable low-voltage monitor
// How it works
// - compare supply to selected level, request interrupt
// - exactly eight selectable trip levels
// - trip codes map 111=4.5V down to 000=1.9V
// - trip select resets to 100, others zero
// - power enable set powers monitor and reference
// - power enable clear powers everything down
// - reference stable flag read-only, resets zero
// - stable flag reads one once monitor settled
// - stable flag valid only with fast oscillator
// - control bits 7, 6, 3 read zero
// - trim comes from protected calibration word
// - low-voltage flag and enable at bit 2
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module lvd_top #(
  parameter int unsigned SETTLE_CYCLES = lvd_pkg::SETTLE_CYCLES
)(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_supply_low,
  input wire logic i_ref_ready,
  input wire logic i_fast_osc_on,
  input wire logic [7:0] i_trim_word,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic o_monitor_power,
  output logic [2:0] o_trip_level,
  output logic [7:0] o_trim
);

  localparam int unsigned CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);

  // ---------------- pin synchronisation
  lvd_sync_if #(.W(lvd_pkg::SYNC_WIDTH)) pins ();

  // the trim byte is a static fuse image, so a wide level sync is safe
  assign pins.raw = {i_trim_word, i_fast_osc_on, i_ref_ready, i_supply_low};

  lvd_sync #(.W(lvd_pkg::SYNC_WIDTH)) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .port(pins)
  );

  logic supply_low_s;
  logic ref_ready_s;
  logic fast_osc_s;
  logic [7:0] trim_s;
  assign supply_low_s = pins.sync[0];
  assign ref_ready_s = pins.sync[1];
  assign fast_osc_s = pins.sync[2];
  assign trim_s = pins.sync[10:3];

  // ---------------- register state
  logic [7:0] core_irq;
  logic flag;
  logic irq_en;
  logic pwr_en;
  lvd_pkg::lvd_trip_type trip;
  logic stable;
  logic [7:0] rdata;
  logic irq;
  logic [7:0] trim;
  lvd_pkg::lvd_state_type state;
  logic [CW-1:0] cnt;

  logic [7:0] next_core_irq;
  logic next_flag;
  logic next_irq_en;
  logic next_pwr_en;
  lvd_pkg::lvd_trip_type next_trip;
  logic next_stable;
  logic [7:0] next_rdata;
  logic next_irq;
  lvd_pkg::lvd_state_type next_state;
  logic [CW-1:0] next_cnt;

  logic wr_core;
  logic wr_flags;
  logic wr_enables;
  logic wr_ctrl;
  logic flag_set;
  logic flag_clr;

  assign wr_core = i_wr && (i_addr == lvd_pkg::ADDR_CORE_IRQ_CTRL);
  assign wr_flags = i_wr && (i_addr == lvd_pkg::ADDR_PERIPH_FLAGS_TWO);
  assign wr_enables = i_wr && (i_addr == lvd_pkg::ADDR_PERIPH_ENABLES_TWO);
  assign wr_ctrl = i_wr && (i_addr == lvd_pkg::ADDR_LOW_VOLTAGE_CTRL);

  // comparator level is only believed while the monitor is powered
  assign flag_set = pwr_en && supply_low_s;
  assign flag_clr = wr_flags && i_wdata[lvd_pkg::LOW_VOLTAGE_BIT];

  // ---------------- power / settle sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      lvd_pkg::LVD_OFF: begin
        next_cnt = '0;
        if (pwr_en) begin
          next_state = lvd_pkg::LVD_SETTLE;
        end
      end
      lvd_pkg::LVD_SETTLE: begin
        if (!pwr_en) begin
          next_state = lvd_pkg::LVD_OFF;
        end else if (cnt == SETTLE_LAST) begin
          next_state = lvd_pkg::LVD_READY;
        end else begin
          next_cnt = cnt + CW'(1);
        end
      end
      lvd_pkg::LVD_READY: begin
        if (!pwr_en) begin
          next_state = lvd_pkg::LVD_OFF;
        end
      end
      default: begin
        next_state = lvd_pkg::LVD_OFF;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= lvd_pkg::LVD_OFF;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ---------------- registers, flag, interrupt, read port
  always_comb begin
    next_core_irq = core_irq;
    next_irq_en = irq_en;
    next_pwr_en = pwr_en;
    next_trip = trip;
    next_rdata = rdata;
    if (wr_core) begin
      next_core_irq = i_wdata;
    end
    if (wr_enables) begin
      next_irq_en = i_wdata[lvd_pkg::LOW_VOLTAGE_BIT];
    end
    if (wr_ctrl) begin
      // bit 5 and the unimplemented bits are not stored
      next_pwr_en = i_wdata[lvd_pkg::POWER_ENABLE_BIT];
      next_trip = lvd_pkg::lvd_trip_type'(i_wdata[lvd_pkg::TRIP_LSB +: lvd_pkg::TRIP_WIDTH]);
    end
    // a new low reading wins over a same-cycle clear
    next_flag = flag_set || (flag && !flag_clr);
    // settled, powered and timed by the fast oscillator
    next_stable = next_pwr_en && (state == lvd_pkg::LVD_READY) && ref_ready_s && fast_osc_s;
    next_irq = next_flag && next_irq_en && next_core_irq[lvd_pkg::GLOBAL_IRQ_ENABLE_BIT]
      && next_core_irq[lvd_pkg::PERIPH_IRQ_ENABLE_BIT];
    if (i_rd) begin
      case (i_addr)
        lvd_pkg::ADDR_CORE_IRQ_CTRL: next_rdata = core_irq;
        lvd_pkg::ADDR_PERIPH_FLAGS_TWO: next_rdata = 8'(flag) << lvd_pkg::LOW_VOLTAGE_BIT;
        lvd_pkg::ADDR_PERIPH_ENABLES_TWO: next_rdata = 8'(irq_en) << lvd_pkg::LOW_VOLTAGE_BIT;
        lvd_pkg::ADDR_LOW_VOLTAGE_CTRL: next_rdata = {2'h0, stable, pwr_en, 1'h0, trip};
        default: next_rdata = lvd_pkg::READ_UNMAPPED;
      endcase
    end else begin
      next_rdata = lvd_pkg::READ_UNMAPPED;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      core_irq <= lvd_pkg::CORE_IRQ_CTRL_RESET;
      flag <= lvd_pkg::PERIPH_FLAGS_TWO_RESET[lvd_pkg::LOW_VOLTAGE_BIT];
      irq_en <= lvd_pkg::PERIPH_ENABLES_TWO_RESET[lvd_pkg::LOW_VOLTAGE_BIT];
      pwr_en <= lvd_pkg::LOW_VOLTAGE_CTRL_RESET[lvd_pkg::POWER_ENABLE_BIT];
      trip <= lvd_pkg::TRIP_RESET;
      stable <= lvd_pkg::LOW_VOLTAGE_CTRL_RESET[lvd_pkg::REF_STABLE_BIT];
      rdata <= lvd_pkg::READ_UNMAPPED;
      irq <= 1'h0;
      trim <= 8'h00;
    end else begin
      core_irq <= next_core_irq;
      flag <= next_flag;
      irq_en <= next_irq_en;
      pwr_en <= next_pwr_en;
      trip <= next_trip;
      stable <= next_stable;
      rdata <= next_rdata;
      irq <= next_irq;
      trim <= trim_s;
    end
  end

  assign o_rdata = rdata;
  assign o_irq = irq;
  assign o_monitor_power = pwr_en;
  assign o_trip_level = trip;
  assign o_trim = trim;

  // ---------------- checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  // irq is registered from the same next values as the flag and enables, so it tracks them exactly
  chk_irq_gating: assert property (
    o_irq == (flag && irq_en && core_irq[lvd_pkg::GLOBAL_IRQ_ENABLE_BIT]
      && core_irq[lvd_pkg::PERIPH_IRQ_ENABLE_BIT]))
    else $error("interrupt output not gated by flag and enables");

  chk_ctrl_readback: assert property (
    i_rd && i_addr == lvd_pkg::ADDR_LOW_VOLTAGE_CTRL |=>
      o_rdata[7:6] == 2'h0 && o_rdata[3] == 1'h0 && o_rdata[2:0] == $past(trip)
      && o_rdata[4] == $past(pwr_en) && o_rdata[5] == $past(stable))
    else $error("control register readback wrong");

  chk_stable_needs_power: assert property (
    stable |-> pwr_en)
    else $error("stable flag set while monitor disabled");

  chk_flag_sticky: assert property (
    flag && !flag_clr |=> flag)
    else $error("low-voltage flag dropped without clear");

  chk_flag_sets: assert property (
    pwr_en && supply_low_s |=> flag)
    else $error("low supply not flagged");

  chk_no_event_off: assert property (
    !pwr_en && (!flag || flag_clr) |=> !flag)
    else $error("event flagged while monitor disabled");

  chk_stable_write_ignored: assert property (
    wr_ctrl && i_wdata[5] && state != lvd_pkg::LVD_READY |=> !stable)
    else $error("write reached the stable flag");

  chk_settle_wait: assert property (
    $rose(pwr_en) |-> !stable ##1 !stable [*2])
    else $error("stable flag set before settling");

  chk_trip_write: assert property (
    wr_ctrl |=> o_trip_level == $past(i_wdata[2:0]) && o_monitor_power == $past(i_wdata[4]))
    else $error("trip level or power enable not written");

  chk_osc_needed: assert property (
    !fast_osc_s |=> !stable)
    else $error("stable flag set without fast oscillator");

  chk_stable_when_ready: assert property (
    state == lvd_pkg::LVD_READY && pwr_en && !wr_ctrl && ref_ready_s && fast_osc_s |=> stable)
    else $error("stable flag not set after settling");

  chk_power_on_seq: assert property (
    pwr_en && state == lvd_pkg::LVD_OFF |=> state == lvd_pkg::LVD_SETTLE)
    else $error("power enable did not start settling");

  chk_power_off_seq: assert property (
    !pwr_en |=> state == lvd_pkg::LVD_OFF)
    else $error("monitor not powered down");

  chk_settle_count: assert property (
    state == lvd_pkg::LVD_SETTLE |-> cnt <= SETTLE_LAST)
    else $error("settle counter overran");

  chk_flag_cleared: assert property (
    flag_clr && !flag_set |=> !flag)
    else $error("low-voltage flag not cleared by write");

  chk_flags_readback: assert property (
    i_rd && i_addr == lvd_pkg::ADDR_PERIPH_FLAGS_TWO |=> o_rdata == {5'h00, $past(flag), 2'h0})
    else $error("flag register readback wrong");

  chk_enables_readback: assert property (
    i_rd && i_addr == lvd_pkg::ADDR_PERIPH_ENABLES_TWO |=> o_rdata == {5'h00, $past(irq_en), 2'h0})
    else $error("enable register readback wrong");

  chk_unmapped_read: assert property (
    i_rd && i_addr != lvd_pkg::ADDR_CORE_IRQ_CTRL && i_addr != lvd_pkg::ADDR_PERIPH_FLAGS_TWO
      && i_addr != lvd_pkg::ADDR_PERIPH_ENABLES_TWO && i_addr != lvd_pkg::ADDR_LOW_VOLTAGE_CTRL
      |=> o_rdata == lvd_pkg::READ_UNMAPPED)
    else $error("unmapped read not zero");

  chk_rdata_idle: assert property (
    !i_rd |=> o_rdata == lvd_pkg::READ_UNMAPPED)
    else $error("read data outside read cycle");

  chk_trim_follow: assert property (
    o_trim == $past(trim_s))
    else $error("trim output not following fuse image");

endmodule : lvd_top
`default_nettype wire

/* tb/lvd_top_tb.sv */
// lvd_top_tb: self-checking bench for the low-voltage monitor registers and interrupt
`timescale 1ns/10ps
`default_nettype none
module lvd_top_tb;
  localparam int unsigned SETTLE = 8;
  logic i_clk, i_rstn, i_wr, i_rd, i_supply_low, i_ref_ready, i_fast_osc_on;
  logic [8:0] i_addr;
  logic [7:0] i_wdata, i_trim_word, o_rdata, o_trim, rv, wv;
  logic o_irq, o_monitor_power;
  logic [2:0] o_trip_level;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;

  lvd_top #(.SETTLE_CYCLES(SETTLE)) lvd_top_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_supply_low(i_supply_low), .i_ref_ready(i_ref_ready), .i_fast_osc_on(i_fast_osc_on),
    .i_trim_word(i_trim_word), .o_rdata(o_rdata), .o_irq(o_irq), .o_monitor_power(o_monitor_power),
    .o_trip_level(o_trip_level), .o_trim(o_trim)
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // run is a few hundred cycles; ceiling leaves wide margin
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : wait_cyc

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  function automatic logic [7:0] ctrl_exp(input logic [7:0] w, input logic st);
    return {2'h0, st, w[4], 1'b0, w[2:0]};
  endfunction : ctrl_exp

  task automatic pulse_low(input int n);
    i_supply_low <= 1'b1;
    wait_cyc(n);
    i_supply_low <= 1'b0;
    wait_cyc(4);
  endtask : pulse_low

  initial begin
    i_rstn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 9'h000;
    i_wdata = 8'h00;
    i_supply_low = 1'b0;
    i_ref_ready = 1'b0;
    i_fast_osc_on = 1'b0;
    void'($urandom(37));
    i_trim_word = 8'($urandom);
    wait_cyc(10);
    i_rstn <= 1'b1;
    wait_cyc(1);
    chk({5'h00, o_trip_level}, 8'h04, "reset trip");
    chk({7'h00, o_monitor_power}, 8'h00, "reset power");
    rd(lvd_pkg::ADDR_LOW_VOLTAGE_CTRL, rv);
    chk(rv, 8'h04, "reset ctrl");
    rd(lvd_pkg::ADDR_PERIPH_FLAGS_TWO, rv);
    chk(rv, 8'h00, "reset flags");
    rd(lvd_pkg::ADDR_PERIPH_ENABLES_TWO, rv);
    chk(rv, 8'h00, "reset enables");
    rd(lvd_pkg::ADDR_CORE_IRQ_CTRL, rv);
    chk(rv, 8'h00, "reset core");
    chk(o_trim, i_trim_word, "trim");
    $display("test reset done");

    // every trip code with random junk in the other bits, monitor off
    for (int i = 0; i < 16; i++) begin
      wv = 8'($urandom);
      wv[2:0] = 3'(i);
      wv[4] = 1'b0;
      wr(lvd_pkg::ADDR_LOW_VOLTAGE_CTRL, wv);
      chk({5'h00, o_trip_level}, {5'h00, wv[2:0]}, "trip out");
      rd(lvd_pkg::ADDR_LOW_VOLTAGE_CTRL, rv);
      chk(rv, ctrl_exp(wv, 1'b0), "ctrl mask");
      wv = 8'($urandom);
      wr(lvd_pkg::ADDR_CORE_IRQ_CTRL, wv);
      rd(lvd_pkg::ADDR_CORE_IRQ_CTRL, rv);
      chk(rv, wv, "core rw");
    end
    wr(9'h10c, 8'hff);
    rd(9'h1ff, rv);
    chk(rv, 8'h00, "unmapped read");
    // last control write was code 7 with power off
    rd(lvd_pkg::ADDR_LOW_VOLTAGE_CTRL, rv);
    chk(rv, 8'h07, "unmapped write");
    rd(lvd_pkg::ADDR_CORE_IRQ_CTRL, rv);
    chk(rv, wv, "core kept");
    $display("test codes done");

    i_ref_ready <= 1'b1;
    i_fast_osc_on <= 1'b1;
    wr(lvd_pkg::ADDR_LOW_VOLTAGE_CTRL, 8'h3f);
    chk({7'h00, o_monitor_power}, 8'h01, "power on");
    rd(lvd_pkg::ADDR_LOW_VOLTAGE_CTRL, rv);
    chk(rv, 8'h17, "not yet stable");
    for (int k = 0; k < 20 && rv[5] !== 1'b1; k++) rd(lvd_pkg::ADDR_LOW_VOLTAGE_CTRL, rv);
    chk(rv, 8'h37, "stable");
    i_fast_osc_on <= 1'b0;
    wait_cyc(4);
    rd(lvd_pkg::ADDR_LOW_VOLTAGE_CTRL, rv);
    chk(rv, 8'h17, "osc off");
    i_fast_osc_on <= 1'b1;
    // two sync flops plus the stable register
    wait_cyc(4);
    rd(lvd_pkg::ADDR_LOW_VOLTAGE_CTRL, rv);
    chk(rv, 8'h37, "osc back");
    $display("test settle done");

    wr(lvd_pkg::ADDR_PERIPH_ENABLES_TWO, 8'h04);
    wr(lvd_pkg::ADDR_CORE_IRQ_CTRL, 8'hc0);
    pulse_low(3);
    rd(lvd_pkg::ADDR_PERIPH_FLAGS_TWO, rv);
    chk(rv, 8'h04, "flag sticky");
    // each enable alone must hold the request back
    for (int k = 0; k < 8; k++) begin
      wr(lvd_pkg::ADDR_CORE_IRQ_CTRL, {k[2], k[1], 6'h00});
      wr(lvd_pkg::ADDR_PERIPH_ENABLES_TWO, {5'h00, k[0], 2'h0});
      wait_cyc(2);
      chk({7'h00, o_irq}, {7'h00, k == 7}, "irq gate");
    end
    i_supply_low <= 1'b1;
    wait_cyc(5);
    wr(lvd_pkg::ADDR_PERIPH_FLAGS_TWO, 8'h04);
    rd(lvd_pkg::ADDR_PERIPH_FLAGS_TWO, rv);
    chk(rv, 8'h04, "set beats clear");
    i_supply_low <= 1'b0;
    wait_cyc(4);
    wr(lvd_pkg::ADDR_PERIPH_FLAGS_TWO, 8'h04);
    rd(lvd_pkg::ADDR_PERIPH_FLAGS_TWO, rv);
    chk(rv, 8'h00, "w1c");
    wait_cyc(2);
    chk({7'h00, o_irq}, 8'h00, "irq drop");
    $display("test flag done");

    wr(lvd_pkg::ADDR_LOW_VOLTAGE_CTRL, 8'h07);
    chk({7'h00, o_monitor_power}, 8'h00, "power off");
    rd(lvd_pkg::ADDR_LOW_VOLTAGE_CTRL, rv);
    chk(rv, 8'h07, "off not stable");
    pulse_low(6);
    rd(lvd_pkg::ADDR_PERIPH_FLAGS_TWO, rv);
    chk(rv, 8'h00, "off no flag");
    chk({7'h00, o_irq}, 8'h00, "off no irq");
    $display("test disabled done");

    // reset in mid-run must bring back the defaults over written values
    i_rstn <= 1'b0;
    wait_cyc(2);
    chk({5'h00, o_trip_level}, 8'h04, "mid reset trip");
    i_rstn <= 1'b1;
    wait_cyc(2);
    rd(lvd_pkg::ADDR_LOW_VOLTAGE_CTRL, rv);
    chk(rv, 8'h04, "mid reset ctrl");
    rd(lvd_pkg::ADDR_CORE_IRQ_CTRL, rv);
    chk(rv, 8'h00, "mid reset core");
    $display("test mid reset done");
    close_out();
  end
endmodule : lvd_top_tb
`default_nettype wire
